// file: hdl/mrs_pkg.sv
// Package: constants and types for the motion record and status exchange block
package mrs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYCLE_US = 4000;
  localparam int unsigned CYCLE_CLKS = CYCLE_US * (CLK_HZ / 1000000);
  localparam int unsigned RECOVERY_MS = 1000;
  localparam int unsigned RECOVERY_CYC = RECOVERY_MS * 1000 / CYCLE_US;
  localparam int unsigned RUN_HOLD_MS = 80;
  localparam int unsigned RUN_HOLD_CYC = (RUN_HOLD_MS * 1000 + CYCLE_US - 1) / CYCLE_US;
  localparam int unsigned MAIN_CYC_MAX = 255;
  localparam int unsigned IN_BITS = 18;
  localparam int unsigned OUT_BITS = 16;
  localparam int unsigned RANGE_MAX = 31;
  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_MASK = 8'h0C;
  localparam logic [7:0] A_SPEED = 8'h10;
  localparam logic [7:0] A_RELPOS = 8'h14;
  localparam logic [7:0] A_ABSPOS = 8'h18;
  localparam logic [7:0] A_FLAGS = 8'h1C;
  localparam logic [7:0] A_RANGE = 8'h20;
  localparam logic [7:0] A_RX = 8'h24;
  localparam logic [7:0] A_TX = 8'h28;
  localparam logic [7:0] A_MAINCYC = 8'h2C;
  // Control bits
  localparam int unsigned C_RUN = 0;
  localparam int unsigned C_ERR = 1;
  // Interrupt event bits
  localparam int unsigned E_CYCLE = 0;
  localparam int unsigned E_INVALID = 1;
  localparam int unsigned E_RUN = 2;
  localparam int unsigned E_BITS = 3;
  localparam logic [7:0] MAIN_CYC_RST = 8'h01;
  typedef struct packed {
    logic signed [15:0] speed;
    logic speed_ok;
    logic signed [31:0] rel_pos;
    logic rel_ok;
    logic signed [31:0] abs_pos;
    logic abs_ok;
  } mrs_kin_t;
endpackage : mrs_pkg

// file: hdl/mrs_valid_if.sv
// Interface: one validity tracker between top and its recovery counter
`timescale 1ns/1ps
`default_nettype none
interface mrs_valid_if;
  logic tick;
  logic raw_ok;
  logic ok;
  modport owner (output tick, output raw_ok, input ok);
  modport gate (input tick, input raw_ok, output ok);
endinterface : mrs_valid_if
`default_nettype wire

// file: hdl/mrs_valid_gate.sv
// Validity gate with one-second recovery after a drop
`timescale 1ns/1ps
`default_nettype none
module mrs_valid_gate
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  mrs_valid_if.gate vif
);
  logic [7:0] cnt_q;
  logic ok_q;
  wire logic done;
  assign done = (cnt_q >= 8'(RECOVERY_CYC));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      ok_q <= 1'b0;
    end else if (vif.tick) begin
      if (!vif.raw_ok) begin
        cnt_q <= 8'h00;
        ok_q <= 1'b0;
      end else if (!ok_q && !done) begin
        cnt_q <= cnt_q + 8'h01;
      end else begin
        ok_q <= 1'b1;
      end
    end
  end
  assign vif.ok = ok_q;
endmodule : mrs_valid_gate
`default_nettype wire

// file: hdl/mrs_core.sv
// Top: logic cycle, kinematic record, range byte and process bit exchange
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Logic runs once per fixed 4 ms cycle; times count in cycles.
// - Cycle derived from exact clock division, well inside tolerances.
// - Each element has a validity flag; invalid values read zero.
// - Relative position valid only while speed valid.
// - Absolute position and its flag are always zero.
// - Dropped flag returns only after 1 s of valid data.
// - Relative position count starts at zero when measurement begins.
// - Range byte: zero invalid, 1 to 31 range index.
// - 18 bits in from main controller, 16 bits out to it.
// - Outgoing bits hold each state at least one main cycle.
// - After Run, incoming bits read zero for 80 ms plus one main cycle.
// - First-cycle indicator is one only in the first logic cycle.
// - On error, process data and outputs go to zero.
// - Loopback inputs see the previous cycle's outputs.
module mrs_core
  import mrs_pkg::*;
#(
  parameter int unsigned TICK_CLKS = CYCLE_CLKS
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic signed [15:0] enc_speed,
  input wire logic enc_speed_ok,
  input wire logic signed [31:0] enc_delta,
  input wire logic enc_pos_ok,
  input wire logic [7:0] range_in,
  input wire logic [IN_BITS-1:0] main_bits_in,
  input wire logic [OUT_BITS-1:0] logic_bits_out,
  output logic [IN_BITS-1:0] main_bits_rx,
  output logic [OUT_BITS-1:0] main_bits_tx,
  output logic [OUT_BITS-1:0] loop_bits,
  output mrs_kin_t kinematic_record,
  output logic [7:0] range_index_byte,
  output logic first_cycle,
  output logic cycle_tick
);
  function automatic logic [7:0] range_ok(input logic [7:0] v);
    range_ok = (v <= 8'(RANGE_MAX)) ? v : 8'h00;
  endfunction : range_ok

  // Input synchronisers
  logic [IN_BITS-1:0] rx_s1_q, rx_s2_q;
  logic [15:0] spd_s1_q, spd_s2_q;
  logic [31:0] dlt_s1_q, dlt_s2_q;
  logic [1:0] ok_s1_q, ok_s2_q;
  logic [7:0] rng_s1_q, rng_s2_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= '0;
      rx_s2_q <= '0;
      spd_s1_q <= 16'h0000;
      spd_s2_q <= 16'h0000;
      dlt_s1_q <= 32'h0000_0000;
      dlt_s2_q <= 32'h0000_0000;
      ok_s1_q <= 2'h0;
      ok_s2_q <= 2'h0;
      rng_s1_q <= 8'h00;
      rng_s2_q <= 8'h00;
    end else begin
      rx_s1_q <= main_bits_in;
      rx_s2_q <= rx_s1_q;
      spd_s1_q <= enc_speed;
      spd_s2_q <= spd_s1_q;
      dlt_s1_q <= enc_delta;
      dlt_s2_q <= dlt_s1_q;
      ok_s1_q <= {enc_pos_ok, enc_speed_ok};
      ok_s2_q <= ok_s1_q;
      rng_s1_q <= range_in;
      rng_s2_q <= rng_s1_q;
    end
  end

  // Registers
  logic [1:0] ctrl_q;
  logic [3:0] ist_q, imask_q;
  logic [7:0] main_cyc_q;
  wire logic wr_ctrl = wr && (addr == A_CTRL);
  wire logic wr_ist = wr && (addr == A_IRQ_STAT);
  wire logic wr_imask = wr && (addr == A_IRQ_MASK);
  wire logic wr_mcyc = wr && (addr == A_MAINCYC);
  wire logic run = ctrl_q[C_RUN];
  wire logic err = ctrl_q[C_ERR];

  // Logic cycle timer
  localparam int unsigned DIV_W = $clog2(TICK_CLKS);
  logic [DIV_W-1:0] div_q;
  wire logic tick = (div_q == DIV_W'(TICK_CLKS - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + DIV_W'(1);
    end
  end

  // Validity trackers
  mrs_valid_if spd_vif();
  mrs_valid_if pos_vif();
  assign spd_vif.tick = tick;
  assign spd_vif.raw_ok = ok_s2_q[0] && run && !err;
  assign pos_vif.tick = tick;
  assign pos_vif.raw_ok = ok_s2_q[1] && ok_s2_q[0] && run && !err;
  mrs_valid_gate u_spd_gate (.mclk(mclk), .rst_n(rst_n), .vif(spd_vif));
  mrs_valid_gate u_pos_gate (.mclk(mclk), .rst_n(rst_n), .vif(pos_vif));

  // Run hold and first cycle
  logic run_d1_q;
  logic [8:0] hold_q;
  logic first_q, started_q;
  wire logic run_rise = run && !run_d1_q;
  wire logic hold_act = (hold_q != 9'h000);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_d1_q <= 1'b0;
      hold_q <= 9'h000;
      first_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      run_d1_q <= run;
      if (run_rise) begin
        hold_q <= 9'(RUN_HOLD_CYC) + {1'b0, main_cyc_q};
      end else if (tick && hold_act) begin
        hold_q <= hold_q - 9'h001;
      end
      if (tick) begin
        first_q <= run && !started_q;
        started_q <= started_q | run;
      end
      if (!run) begin
        started_q <= 1'b0;
      end
    end
  end

  // Kinematic record, updated as a whole each cycle
  mrs_kin_t rec_q;
  logic [7:0] range_q;
  logic [IN_BITS-1:0] rx_q;
  logic [OUT_BITS-1:0] tx_q, loop_q;
  logic [7:0] hold_cnt_q;
  wire logic signed [31:0] rel_next = pos_vif.ok ? (rec_q.rel_pos + $signed(dlt_s2_q)) : 32'sh0000_0000;
  wire logic tx_change = (logic_bits_out != tx_q);
  wire logic tx_may = (hold_cnt_q >= main_cyc_q);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rec_q <= '0;
      range_q <= 8'h00;
      rx_q <= '0;
      tx_q <= '0;
      loop_q <= '0;
      hold_cnt_q <= 8'h00;
    end else if (tick) begin
      rec_q.speed <= spd_vif.ok ? $signed(spd_s2_q) : 16'sh0000;
      rec_q.speed_ok <= spd_vif.ok;
      rec_q.rel_pos <= (pos_vif.ok && spd_vif.ok) ? rel_next : 32'sh0000_0000;
      rec_q.rel_ok <= pos_vif.ok && spd_vif.ok;
      rec_q.abs_pos <= 32'sh0000_0000;
      rec_q.abs_ok <= 1'b0;
      range_q <= err ? 8'h00 : range_ok(rng_s2_q);
      rx_q <= (hold_act || err || !run) ? '0 : rx_s2_q;
      loop_q <= tx_q;
      if (err || !run) begin
        tx_q <= '0;
        hold_cnt_q <= 8'h00;
      end else if (tx_change && tx_may) begin
        tx_q <= logic_bits_out;
        hold_cnt_q <= 8'h01;
      end else if (hold_cnt_q != 8'hFF) begin
        hold_cnt_q <= hold_cnt_q + 8'h01;
      end
    end
  end

  // Register bus and interrupts
  wire logic [3:0] events = {tx_change && tx_may && tick, run_rise, tick && rec_q.speed_ok && !spd_vif.ok, tick};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 2'h0;
      imask_q <= 4'h0;
      ist_q <= 4'h0;
      main_cyc_q <= MAIN_CYC_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata[1:0];
      if (wr_imask) imask_q <= wdata[3:0];
      if (wr_mcyc) main_cyc_q <= (wdata[7:0] == 8'h00) ? MAIN_CYC_RST : wdata[7:0];
      ist_q <= (ist_q & ~(wr_ist ? wdata[3:0] : 4'h0)) | events;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      A_CTRL: rd_mux = {30'h0, ctrl_q};
      A_STATUS: rd_mux = {27'h0, first_q, hold_act, pos_vif.ok, spd_vif.ok, run};
      A_IRQ_STAT: rd_mux = {28'h0, ist_q};
      A_IRQ_MASK: rd_mux = {28'h0, imask_q};
      A_SPEED: rd_mux = {{16{rec_q.speed[15]}}, rec_q.speed};
      A_RELPOS: rd_mux = rec_q.rel_pos;
      A_ABSPOS: rd_mux = rec_q.abs_pos;
      A_FLAGS: rd_mux = {29'h0, rec_q.abs_ok, rec_q.rel_ok, rec_q.speed_ok};
      A_RANGE: rd_mux = {24'h0, range_q};
      A_RX: rd_mux = {14'h0, rx_q};
      A_TX: rd_mux = {16'h0, tx_q};
      A_MAINCYC: rd_mux = {24'h0, main_cyc_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign irq = |(ist_q & imask_q);
  assign kinematic_record = rec_q;
  assign range_index_byte = range_q;
  assign main_bits_rx = rx_q;
  assign main_bits_tx = tx_q;
  assign loop_bits = loop_q;
  assign first_cycle = first_q;
  assign cycle_tick = tick;
endmodule : mrs_core
`default_nettype wire

// file: dv/mrs_main_model.sv
// Main controller model: drives process bits and samples returned bits
`timescale 1ns/1ps
`default_nettype none
module mrs_main_model
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [OUT_BITS-1:0] bits_from_dev,
  output logic [IN_BITS-1:0] bits_to_dev,
  output logic [OUT_BITS-1:0] seen_q
);
  localparam logic [IN_BITS-1:0] PATTERN = 18'h2D2D2;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bits_to_dev <= '0;
      seen_q <= '0;
    end else begin
      bits_to_dev <= PATTERN;
      if (tick) seen_q <= bits_from_dev;
    end
  end
endmodule : mrs_main_model
`default_nettype wire

// file: dv/mrs_core_monitor.sv
// Checker for the motion record block ports
`timescale 1ns/1ps
`default_nettype none
module mrs_core_monitor
  import mrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cycle_tick,
  input wire logic first_cycle,
  input wire logic [OUT_BITS-1:0] main_bits_tx,
  input wire logic [OUT_BITS-1:0] loop_bits,
  input wire mrs_kin_t kinematic_record,
  input wire logic [7:0] range_index_byte
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_abs_zero: assert property (kinematic_record.abs_pos == 32'h0 && !kinematic_record.abs_ok)
    else $error("absolute position not zero");
  a_speed_zero: assert property (!kinematic_record.speed_ok |-> kinematic_record.speed == 16'h0)
    else $error("invalid speed not zero");
  a_relpos_zero: assert property (!kinematic_record.rel_ok |-> kinematic_record.rel_pos == 32'h0)
    else $error("invalid position not zero");
  a_rel_needs_speed: assert property (kinematic_record.rel_ok |-> kinematic_record.speed_ok)
    else $error("position valid without speed");
  a_record_coherent: assert property (!$past(cycle_tick) |-> $stable(kinematic_record))
    else $error("record changed off tick");
  a_range_limit: assert property (range_index_byte <= 8'h1F)
    else $error("range byte above limit");
  a_first_drop: assert property ($fell(first_cycle) |-> $past(cycle_tick))
    else $error("first cycle fell off tick");
  a_loop_delay: assert property ($past(cycle_tick) |-> loop_bits == $past(main_bits_tx))
    else $error("loop bits not previous tx");
  c_first: cover property (cycle_tick && first_cycle);
  c_first_end: cover property ($fell(first_cycle));
  c_range: cover property (range_index_byte == 8'h07);
  c_rel_valid: cover property (kinematic_record.rel_ok);
endmodule : mrs_core_monitor
`default_nettype wire

// file: dv/test_motion_record_status_exchange.sv
// Testbench for the motion record and status exchange block
`timescale 1ns/1ps
`default_nettype none
module test_motion_record_status_exchange
  import mrs_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e;} mrs_row_t;
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0, irq, first_cycle, cycle_tick;
  logic enc_speed_ok = 1, enc_pos_ok = 1;
  logic [7:0] addr = 8'h00, range_in = 8'h07, range_index_byte;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic signed [15:0] enc_speed = 16'h1234;
  logic signed [31:0] enc_delta = 32'h5;
  logic [IN_BITS-1:0] main_bits_in, main_bits_rx;
  logic [OUT_BITS-1:0] logic_bits_out = 16'hA5A5, main_bits_tx, loop_bits, seen;
  localparam int unsigned TB_TICK = 40;
  mrs_kin_t kin;
  int fail_count = 0, checks = 0, cycles = 0;
  mrs_row_t rows [6] = '{'{A_MAINCYC, 32'h0, 1'b1, 32'h1}, '{A_MAINCYC, 32'h2, 1'b1, 32'h2},
    '{A_IRQ_MASK, 32'hF, 1'b1, 32'hF}, '{A_CTRL, 32'h1, 1'b1, 32'h1},
    '{A_ABSPOS, 32'h0, 1'b0, 32'h0}, '{8'h30, 32'hFFFF, 1'b1, 32'h0}};
  always #12.5 mclk = ~mclk;
  mrs_core #(.TICK_CLKS(TB_TICK)) i_mrs_core (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd),
    .rdata(rdata), .irq(irq), .enc_speed(enc_speed), .enc_speed_ok(enc_speed_ok), .enc_delta(enc_delta),
    .enc_pos_ok(enc_pos_ok), .range_in(range_in), .main_bits_in(main_bits_in),
    .logic_bits_out(logic_bits_out), .main_bits_rx(main_bits_rx), .main_bits_tx(main_bits_tx),
    .loop_bits(loop_bits), .kinematic_record(kin), .range_index_byte(range_index_byte),
    .first_cycle(first_cycle), .cycle_tick(cycle_tick));
  mrs_main_model i_mrs_main_model (.mclk(mclk), .rst_n(rst_n), .tick(cycle_tick), .bits_from_dev(main_bits_tx),
    .bits_to_dev(main_bits_in), .seen_q(seen));
  task automatic check(input logic [82:0] seen, input logic [82:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge mclk) wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk) begin addr <= a; rd <= 1'b1; end
    @(posedge mclk) rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic tick();
    #1;
    while (cycle_tick !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1;
  endtask : tick
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rv);
      check(rv, rows[i].e);
    end
    $display("Register table done");
    tick();
    check(first_cycle, 1'b1);
    check(range_index_byte, 8'h07);
    check(kin.speed_ok, 1'b0);
    check(kin, '0);
    check(main_bits_rx, '0);
    check(irq, 1'b1);
    rd_reg(A_IRQ_STAT, rv);
    check(rv, 32'h5);
    wr_reg(A_IRQ_STAT, 32'hF);
    check(irq, 1'b0);
    @(posedge mclk) range_in <= 8'h28;
    tick();
    check(first_cycle, 1'b0);
    check(range_index_byte, 8'h00);
    check(irq, 1'b1);
    @(posedge mclk) range_in <= 8'h1F;
    tick();
    check(range_index_byte, 8'h1F);
    check(main_bits_tx, 16'hA5A5);
    check(loop_bits, '0);
    $display("Logic cycles done");
    @(posedge mclk) logic_bits_out <= 16'h5A5A;
    tick();
    check(main_bits_tx, 16'hA5A5);
    check(loop_bits, 16'hA5A5);
    check(seen, 16'hA5A5);
    tick();
    check(main_bits_tx, 16'h5A5A);
    check(main_bits_rx, '0);
    repeat (17) tick();
    check(main_bits_rx, '0);
    tick();
    check(main_bits_rx, 18'h2D2D2);
    $display("Process bit exchange done");
    repeat (228) tick();
    check(kin.speed_ok, 1'b0);
    tick();
    check(kin.speed_ok, 1'b1);
    check(kin.speed, 16'h1234);
    check(kin.rel_ok, 1'b1);
    check(kin.rel_pos, 32'h5);
    tick();
    check(kin.rel_pos, 32'hA);
    $display("Validity recovery done");
    @(posedge mclk) enc_speed_ok <= 1'b0;
    repeat (2) tick();
    check(kin.speed_ok, 1'b0);
    check(kin.speed, 16'h0000);
    check(kin.rel_ok, 1'b0);
    check(kin.rel_pos, 32'h0);
    rd_reg(A_IRQ_STAT, rv);
    check(rv[E_INVALID], 1'b1);
    @(posedge mclk) enc_speed_ok <= 1'b1;
    repeat (3) tick();
    check(kin.speed_ok, 1'b0);
    $display("Validity drop done");
    wr_reg(A_CTRL, 32'h3);
    tick();
    check(range_index_byte, 8'h00);
    check(main_bits_tx, '0);
    check(main_bits_rx, '0);
    $display("Error handling done");
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    #1 check({first_cycle, irq, kin.rel_pos}, '0);
    rd_reg(A_MAINCYC, rv);
    check(rv, 32'h1);
    $display("Reset test done");
    summarize();
  end
endmodule : test_motion_record_status_exchange
bind mrs_core mrs_core_monitor i_mrs_core_monitor (.mclk(mclk), .rst_n(rst_n), .cycle_tick(cycle_tick),
  .first_cycle(first_cycle), .main_bits_tx(main_bits_tx), .loop_bits(loop_bits),
  .kinematic_record(kinematic_record), .range_index_byte(range_index_byte));
`default_nettype wire
